// ===== pkg/docu_pkg.sv
package docu_pkg;
  // ****************************************
  // Widths and register map
  // ****************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int EVT_NUM = 3;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_REF = 4'h1;
  localparam logic [3:0] ADDR_INPUT = 4'h2;
  localparam logic [3:0] ADDR_RESULT = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h5;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_MSB = 1;
  localparam int CTRL_POL_BIT = 2;
  localparam int CTRL_FLAG_BIT = 3;
  localparam int EVT_CMP = 0;
  localparam int EVT_ADD = 1;
  localparam int EVT_SUB = 2;

  // ****************************************
  // Codes and reset values
  // ****************************************
  localparam logic [1:0] MODE_CODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CODE_ADD = 2'h1;
  localparam logic [1:0] MODE_CODE_SUB = 2'h2;
  localparam logic [15:0] REF_RST = 16'h0000;
  localparam logic [15:0] INPUT_RST = 16'h0000;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic POL_RST = 1'b0;

  typedef enum logic [2:0] {
    MODE_CMP = 3'b001,
    MODE_ADD = 3'b010,
    MODE_SUB = 3'b100
  } docu_mode_t;
endpackage

// ===== pkg/docu_op_if.sv
`timescale 1ns/10ps
interface docu_op_if #(
  parameter int W = 16
);
  logic [W-1:0] inOperand;
  logic [W-1:0] refOperand;
  logic [W-1:0] result;
  docu_pkg::docu_mode_t mode;
  logic mismatchSel;
  logic hit;

  modport ctrl (
    output inOperand, refOperand, mode, mismatchSel,
    input result, hit
  );
  modport alu (
    input inOperand, refOperand, mode, mismatchSel,
    output result, hit
  );
endinterface

// ===== design/docu_arith.sv
`timescale 1ns/10ps
module docu_arith #(
  parameter int DATA_W = docu_pkg::DATA_W
) (
  // Operands, mode and outcome
  docu_op_if.alu op
);
  import docu_pkg::*;

  // Extra top bit catches carry and borrow out of the msb
  wire [DATA_W:0] sumExt;
  wire [DATA_W:0] diffExt;
  wire eqHit;
  wire cmpHit;

  assign sumExt = {1'b0, op.inOperand} + {1'b0, op.refOperand};
  assign diffExt = {1'b0, op.inOperand} - {1'b0, op.refOperand};
  assign eqHit = (op.inOperand == op.refOperand);
  assign cmpHit = op.mismatchSel ? !eqHit : eqHit;

  assign op.result = (op.mode == MODE_ADD) ? sumExt[DATA_W-1:0] :
                     (op.mode == MODE_SUB) ? diffExt[DATA_W-1:0] :
                     {{(DATA_W-1){1'b0}}, eqHit};
  assign op.hit = (op.mode == MODE_ADD) ? sumExt[DATA_W] :
                  (op.mode == MODE_SUB) ? diffExt[DATA_W] :
                  cmpHit;
endmodule

// ===== design/docu_flag.sv
`timescale 1ns/10ps
module docu_flag (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Set and clear requests
  input wire logic setEv,
  input wire logic clrEv,
  // Flag
  output logic q
);
  // Set beats clear so no event is lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else if (setEv) begin
      q <= 1'b1;
    end else if (clrEv) begin
      q <= 1'b0;
    end
  end
endmodule

// ===== design/docu_top.sv
// Contract
// - 16-bit operands; compare, add or subtract, exactly one selected.
// - Selected condition met raises an interrupt request. Here it does so only if that event's mask bit is set; the mask resets to 0.
// - Compare detects equality, signalling on match or mismatch by polarity.
// - Add signals when the sum carries out of bit 15.
// - Subtract signals when the difference borrows out of bit 15.
// - Reference register holds the threshold, loaded before input operands.
// - Each write to the input register is evaluated against the reference.
// - A negative subtraction sets the result flag in the control register.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module docu_top #(
  parameter int DATA_W = docu_pkg::DATA_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [docu_pkg::ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData,
  // Interrupt and flag
  output logic irq,
  output logic opFlag
);
  import docu_pkg::*;

  // ****************************************
  // State
  // ****************************************
  docu_mode_t mode;
  logic mismatchSel;
  logic [DATA_W-1:0] refOperand;
  logic [DATA_W-1:0] inOperand;
  logic [DATA_W-1:0] lastResult;
  logic [EVT_NUM-1:0] mask;
  logic [EVT_NUM-1:0] status;

  docu_op_if #(.W(DATA_W)) op ();

  // ****************************************
  // Address decode
  // ****************************************
  wire wrCtrl;
  wire wrRef;
  wire wrIn;
  wire wrMask;
  wire rdStatus;

  assign wrCtrl = regWr && (regAddr == ADDR_CTRL);
  assign wrRef = regWr && (regAddr == ADDR_REF);
  assign wrIn = regWr && (regAddr == ADDR_INPUT);
  assign wrMask = regWr && (regAddr == ADDR_MASK);
  assign rdStatus = regRd && (regAddr == ADDR_STATUS);

  // ****************************************
  // Mode decode
  // ****************************************
  wire [1:0] modeCode;
  wire modeCodeOk;
  docu_mode_t modeDecoded;
  docu_mode_t next_mode;

  assign modeCode = regWrData[CTRL_MODE_MSB:CTRL_MODE_LSB];
  assign modeCodeOk = (modeCode != 2'h3);
  assign modeDecoded = (modeCode == MODE_CODE_ADD) ? MODE_ADD :
                       (modeCode == MODE_CODE_SUB) ? MODE_SUB :
                       MODE_CMP;
  // Reserved code keeps the old mode rather than a bogus one
  assign next_mode = (wrCtrl && modeCodeOk) ? modeDecoded : mode;

  // ****************************************
  // Operand path
  // ****************************************
  // evaluate on write
  assign op.inOperand = wrIn ? regWrData : inOperand;
  assign op.refOperand = refOperand;
  assign op.mode = mode;
  assign op.mismatchSel = mismatchSel;

  docu_arith #(.DATA_W(DATA_W)) u_arith (
    .op(op.alu)
  );

  // ****************************************
  // Events
  // ****************************************
  wire evalHit;
  wire [EVT_NUM-1:0] evtSet;
  wire [EVT_NUM-1:0] statusClr;
  wire flagClr;

  assign evalHit = wrIn && op.hit;
  assign evtSet[EVT_CMP] = evalHit && (mode == MODE_CMP);
  assign evtSet[EVT_ADD] = evalHit && (mode == MODE_ADD);
  assign evtSet[EVT_SUB] = evalHit && (mode == MODE_SUB);
  assign statusClr = rdStatus ? {EVT_NUM{1'b1}} : {EVT_NUM{1'b0}};
  assign flagClr = wrCtrl && !regWrData[CTRL_FLAG_BIT];

  // ****************************************
  // Sticky flags
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < EVT_NUM; gi++) begin : g_evt
      docu_flag u_stat (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .setEv(evtSet[gi]),
        .clrEv(statusClr[gi]),
        .q(status[gi])
      );
    end
  endgenerate

  docu_flag u_opflag (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .setEv(evalHit),
    .clrEv(flagClr),
    .q(opFlag)
  );

  // ****************************************
  // Control and operand registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MODE_CMP;
      mismatchSel <= POL_RST;
    end else begin
      mode <= next_mode;
      mismatchSel <= wrCtrl ? regWrData[CTRL_POL_BIT] : mismatchSel;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      refOperand <= REF_RST;
    end else if (wrRef) begin
      refOperand <= regWrData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inOperand <= INPUT_RST;
      lastResult <= INPUT_RST;
    end else if (wrIn) begin
      inOperand <= regWrData;
      lastResult <= op.result;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask <= MASK_RST;
    end else if (wrMask) begin
      mask <= regWrData[EVT_NUM-1:0];
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  wire next_irq;

  assign next_irq = |(status & mask);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  wire [DATA_W-1:0] ctrlView;
  wire [DATA_W-1:0] rdMux;
  wire [1:0] modeView;

  assign modeView = (mode == MODE_ADD) ? MODE_CODE_ADD :
                    (mode == MODE_SUB) ? MODE_CODE_SUB :
                    MODE_CODE_CMP;
  assign ctrlView = {{(DATA_W-4){1'b0}}, opFlag, mismatchSel, modeView};
  // Unmapped addresses read as zero
  assign rdMux = (regAddr == ADDR_CTRL) ? ctrlView :
                 (regAddr == ADDR_REF) ? refOperand :
                 (regAddr == ADDR_INPUT) ? inOperand :
                 (regAddr == ADDR_RESULT) ? lastResult :
                 (regAddr == ADDR_STATUS) ?
                   {{(DATA_W-EVT_NUM){1'b0}}, status} :
                 (regAddr == ADDR_MASK) ?
                   {{(DATA_W-EVT_NUM){1'b0}}, mask} :
                 {DATA_W{1'b0}};

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= '0;
    end else begin
      regRdData <= regRd ? rdMux : '0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  wire [DATA_W:0] chkSum;
  wire chkBorrow;
  assign chkSum = {1'b0, regWrData} + {1'b0, refOperand};
  assign chkBorrow = (regWrData < refOperand);

  sequence subWrite;
    wrIn && (mode == MODE_SUB) && chkBorrow;
  endsequence

  sequence flagThenIrq;
    status[EVT_SUB] ##1 irq;
  endsequence

  mode_onehot_a:
    assert property ($onehot(mode))
      else $error("operation mode not one-hot");

  irq_raise_a:
    assert property (subWrite and mask[EVT_SUB] |=> flagThenIrq)
      else $error("masked event did not raise irq");

  cmp_event_a:
    assert property (wrIn && (mode == MODE_CMP) &&
      ((regWrData == refOperand) != mismatchSel) |=> status[EVT_CMP])
      else $error("compare event missed");

  cmp_quiet_a:
    assert property (wrIn && (mode == MODE_CMP) &&
      ((regWrData == refOperand) == mismatchSel) && !status[EVT_CMP]
      |=> !status[EVT_CMP])
      else $error("compare event raised wrongly");

  add_carry_a:
    assert property (wrIn && (mode == MODE_ADD) && chkSum[DATA_W]
      |=> status[EVT_ADD])
      else $error("add carry not flagged");

  sub_borrow_a:
    assert property (wrIn && (mode == MODE_SUB) && !chkBorrow &&
      !status[EVT_SUB] |=> !status[EVT_SUB])
      else $error("borrow flagged without borrow");

  ref_load_a:
    assert property (wrRef |=> refOperand == $past(regWrData))
      else $error("reference operand not loaded");

  eval_on_write_a:
    assert property ($rose(status[EVT_ADD]) |-> $past(wrIn))
      else $error("event without input write");

  sub_flag_a:
    assert property (subWrite |=> opFlag && status[EVT_SUB])
      else $error("negative result did not set flag");

  flag_hold_a:
    assert property (opFlag && !flagClr |=> opFlag)
      else $error("result flag dropped without clear");

  // ****************************************
  // Checks on control, capture, read-back, events, flag and interrupt
  // ****************************************
  sequence quietRead;
    rdStatus && !wrIn;
  endsequence

  mode_load_a:
    assert property (wrCtrl &&
      (regWrData[CTRL_MODE_MSB:CTRL_MODE_LSB] == MODE_CODE_ADD)
      |=> mode == MODE_ADD)
      else $error("add mode not loaded");

  mode_keep_a:
    assert property (wrCtrl &&
      (regWrData[CTRL_MODE_MSB:CTRL_MODE_LSB] == 2'h3)
      |=> mode == $past(mode))
      else $error("reserved mode code changed mode");

  irq_drop_a:
    assert property (quietRead |-> ##2 !irq)
      else $error("irq stayed high after status read");

  status_hold_a:
    assert property (status[EVT_ADD] && !rdStatus |=> status[EVT_ADD])
      else $error("sticky status bit lost");

  add_flag_a:
    assert property (wrIn && (mode == MODE_ADD) && chkSum[DATA_W]
      |=> opFlag)
      else $error("add carry did not set flag");

  pol_load_a:
    assert property (wrCtrl |=>
      mismatchSel == $past(regWrData[CTRL_POL_BIT]))
      else $error("compare polarity not loaded");

  add_quiet_a:
    assert property (wrIn && (mode == MODE_ADD) && !chkSum[DATA_W] &&
      !status[EVT_ADD] |=> !status[EVT_ADD])
      else $error("carry flagged without carry");

  sub_result_a:
    assert property (wrIn && (mode == MODE_SUB) |=>
      lastResult == $past(regWrData) - $past(refOperand))
      else $error("difference not captured");

  ref_read_a:
    assert property (regRd && (regAddr == ADDR_REF) |=>
      regRdData == $past(refOperand))
      else $error("reference read-back wrong");

  in_capture_a:
    assert property (wrIn |=> inOperand == $past(regWrData))
      else $error("input operand not captured");

  no_eval_a:
    assert property (!wrIn && !status[EVT_CMP] |=> !status[EVT_CMP])
      else $error("compare event without input write");

  flag_clear_a:
    assert property (flagClr |=> !opFlag)
      else $error("result flag not cleared");
endmodule

// ===== sim/docu_master.sv
`timescale 1ns/10ps
module docu_master (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [docu_pkg::ADDR_W-1:0] regAddr,
  output logic [docu_pkg::DATA_W-1:0] regWrData,
  output logic regWr,
  output logic regRd
);
  import docu_pkg::*;
  // ****
  // Bus master
  // ****
  int gap = 0;

  initial begin
    regAddr <= 4'h0;
    regWrData <= 16'h0000;
    regWr <= 1'b0;
    regRd <= 1'b0;
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    // Released bus must not echo stale data
    regWrData <= ~d;
    regAddr <= ~a;
  endtask

  task automatic rd(input logic [3:0] a);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    regAddr <= ~a;
  endtask
endmodule

// ===== sim/docu_top_test.sv
`timescale 1ns/10ps
module docu_top_test;
  import docu_pkg::*;
  // ****
  // Harness
  // ****
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData;
  logic [DATA_W-1:0] regRdData;
  logic regWr;
  logic regRd;
  logic irq;
  logic opFlag;
  logic rdLast = 1'b0;
  logic [DATA_W-1:0] expQ [$];
  int failCount = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h00016C8F;
  logic [15:0] ctlTab [4] = '{16'h0000, 16'h0004, 16'h0001, 16'h0002};
  logic [3:0] rstAddr [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'hF};

  always #12.5 clk_sys = ~clk_sys;

  docu_top i_docu_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .irq(irq), .opFlag(opFlag)
  );
  docu_master i_docu_master (
    .clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic cmp_data(input logic [15:0] e, input logic [15:0] a);
    compares++;
    if (a !== e) begin
      failCount++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  task automatic cmp_bit(input logic e, input logic a);
    compares++;
    if (a !== e) begin
      failCount++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  task automatic rd_exp(input logic [3:0] a, input logic [15:0] e);
    expQ.push_back(e);
    i_docu_master.rd(a);
  endtask

  task automatic tally_and_finish();
    // Unanswered reads count against the run
    if (expQ.size() != 0) begin
      failCount++;
    end
    $display("Compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****
  // Read-data watcher
  // ****
  always @(posedge clk_sys) begin
    if (rdLast) begin
      cmp_data(expQ.pop_front(), regRdData);
    end else if (rst_n) begin
      cmp_data(16'h0000, regRdData);
    end
    rdLast <= regRd;
  end

  // Hang guard, a few thousand cycles is ample
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failCount++;
      tally_and_finish();
    end
  end

  // ****
  // Sequence
  // ****
  initial begin
    logic [15:0] r;
    logic [15:0] i;
    logic [15:0] res;
    logic [16:0] sum;
    logic [2:0] st;
    logic [2:0] msk;
    logic flag;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (rstAddr[n]) begin
      rd_exp(rstAddr[n], 16'h0000);
    end
    cmp_bit(1'b0, irq);
    cmp_bit(1'b0, opFlag);
    for (int m = 0; m < 4; m++) begin
      i_docu_master.wr(ADDR_CTRL, ctlTab[m]);
      flag = 1'b0;
      for (int k = 0; k < 8; k++) begin
        seed = xs(seed);
        r = seed[15:0];
        msk = seed[18:16];
        i_docu_master.gap = int'(seed[20:19]);
        seed = xs(seed);
        // Equal, one below, sum at wrap point, sum at max, random
        i = (k == 0) ? r : (k == 1) ? r - 16'h0001 :
            (k == 2) ? 16'h0000 - r : (k == 3) ? ~r : seed[15:0];
        sum = {1'b0, i} + {1'b0, r};
        res = (m < 2) ? {15'h0000, i == r} : (m == 2) ? sum[15:0] : i - r;
        case (m)
          0: st = {2'h0, i == r};
          1: st = {2'h0, i != r};
          2: st = {1'h0, sum[16], 1'h0};
          default: st = {i < r, 2'h0};
        endcase
        flag = flag | (|st);
        i_docu_master.wr(ADDR_MASK, {13'h0000, msk});
        i_docu_master.wr(ADDR_REF, r);
        i_docu_master.wr(ADDR_INPUT, i);
        #1;
        cmp_bit(flag, opFlag);
        @(posedge clk_sys);
        #1;
        cmp_bit(|(st & msk), irq);
        rd_exp(ADDR_RESULT, res);
        rd_exp(ADDR_MASK, {13'h0000, msk});
        rd_exp(ADDR_STATUS, {13'h0000, st});
        @(posedge clk_sys);
        #1;
        cmp_bit(1'b0, irq);
      end
      rd_exp(ADDR_CTRL, ctlTab[m] | {12'h000, flag, 3'h0});
      i_docu_master.wr(ADDR_CTRL, ctlTab[m] | 16'h0008);
      #1;
      cmp_bit(flag, opFlag);
      i_docu_master.wr(ADDR_CTRL, ctlTab[m]);
      #1;
      cmp_bit(1'b0, opFlag);
    end
    // Reserved mode code keeps subtraction
    i_docu_master.wr(ADDR_CTRL, 16'h0007);
    rd_exp(ADDR_CTRL, 16'h0006);
    // Leave an event pending so the reset has state to clear
    i_docu_master.wr(ADDR_INPUT, 16'h0000);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_exp(ADDR_CTRL, 16'h0000);
    rd_exp(ADDR_REF, 16'h0000);
    rd_exp(ADDR_STATUS, 16'h0000);
    cmp_bit(1'b0, irq);
    cmp_bit(1'b0, opFlag);
    // Let the watcher take the last read before closing
    repeat (2) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule
